//--- src/crtc_ext_pkg.sv
// Constants and carrier types for the extended CRTC control register bank
package crtc_ext_pkg;

  // Host I/O port addresses
  localparam logic [15:0] PORT_CRTC_IDX_MONO = 16'h03b4;
  localparam logic [15:0] PORT_CRTC_DAT_MONO = 16'h03b5;
  localparam logic [15:0] PORT_CRTC_IDX_COLOR = 16'h03d4;
  localparam logic [15:0] PORT_CRTC_DAT_COLOR = 16'h03d5;
  localparam logic [15:0] PORT_STATUS_MONO = 16'h03ba;
  localparam logic [15:0] PORT_STATUS_COLOR = 16'h03da;
  localparam logic [15:0] PORT_ATTR = 16'h03c0;
  localparam logic [15:0] PORT_MISC_OUT_WR = 16'h03c2;
  localparam logic [15:0] PORT_DAC_FIRST = 16'h03c6;
  localparam logic [15:0] PORT_DAC_LAST = 16'h03c9;

  // Extended register indices
  localparam logic [7:0] IDX_COMPAT_CTRL_TWO = 8'h33;
  localparam logic [7:0] IDX_COMPAT_CTRL_THREE = 8'h34;
  localparam logic [7:0] IDX_CRT_WRITE_LOCK = 8'h35;
  localparam logic [7:0] IDX_MEMORY_CONFIG_ONE = 8'h36;
  localparam logic [7:0] IDX_CHIP_CONFIG_TWO = 8'h37;
  localparam logic [7:0] IDX_UNLOCK_KEY_ONE = 8'h38;
  localparam logic [7:0] IDX_UNLOCK_KEY_TWO = 8'h39;
  localparam logic [7:0] IDX_MISC_CONTROL_ONE = 8'h3a;
  localparam logic [7:0] IDX_FIFO_FETCH_START = 8'h3b;
  localparam logic [7:0] IDX_INTERLACE_RETRACE_START = 8'h3c;
  localparam logic [7:0] IDX_TV_OUTPUT_CONTROL = 8'h3d;
  localparam logic [7:0] IDX_SYSTEM_CONFIG = 8'h40;
  localparam logic [7:0] IDX_BIOS_SCRATCH_FLAG = 8'h41;
  localparam logic [7:0] IDX_DISPLAY_MODE_CONTROL = 8'h42;
  localparam logic [7:0] IDX_EXTENDED_MODE_CTRL = 8'h43;
  localparam logic [7:0] IDX_CURSOR_MODE_CTRL = 8'h45;
  localparam logic [7:0] IDX_KEY_ONE_RANGE_LO = 8'h30;
  localparam logic [7:0] IDX_KEY_ONE_RANGE_HI = 8'h3c;

  // Standard CRTC indices touched by the protection logic
  localparam logic [7:0] IDX_HORIZONTAL_DISPLAY_END = 8'h01;
  localparam logic [7:0] IDX_HORIZ_LAST = 8'h05;
  localparam logic [7:0] IDX_VERTICAL_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_VERTICAL_RETRACE_END = 8'h11;
  localparam logic [7:0] IDX_VERTICAL_DISPLAY_END = 8'h12;

  // Field positions
  localparam int B_VERTICAL_RETRACE_END_REG_PROTECT = 7;
  localparam int B_CR7_ALWAYS = 4;
  localparam int B_CR7_UNPROT_A = 1;
  localparam int B_CR7_UNPROT_B = 6;
  localparam int B_C2_UNPROTECT_CR7 = 1;
  localparam int B_C2_VIDEO_OUT_CLOCK_INVERT = 3;
  localparam int B_C2_DAC_WR_OFF = 4;
  localparam int B_C2_BLANK_FORCE = 5;
  localparam int B_C2_ATTR_WR_OFF = 6;
  localparam int B_C3_SNOOP_METHOD = 0;
  localparam int B_C3_NO_MABORT = 1;
  localparam int B_C3_NO_RETRY = 2;
  localparam int B_C3_FIFO_START_EN = 4;
  localparam int B_C3_FORCE_8DOT = 5;
  localparam int B_C3_DOT_CLOCK_SEL_LOCK = 7;
  localparam int B_LK_VERT = 4;
  localparam int B_LK_HORIZ = 5;
  localparam int B_LK_CR1_MISC6 = 6;
  localparam int B_LK_VERTICAL_DISPLAY_END_REG_MISC7 = 7;
  localparam int B_CF2_TEST_MODE = 1;
  localparam int B_CF2_INTERNAL_CLK = 3;
  localparam int B_MC_REFRESH_ALT_EN = 2;
  localparam int B_MC_PCI_BURST_OFF = 7;
  localparam int B_SC_ENH_ACCESS = 0;
  localparam int B_DM_INTERLACE = 5;
  localparam int B_TV_EN = 0;
  localparam int B_TV_MONO = 4;
  localparam int B_TV_PAL = 5;
  localparam int B_CUR_EN = 0;
  localparam int B_CUR_SPACE = 4;
  localparam logic [7:0] MISC_DOT_CLOCK_MASK = 8'h0c;
  localparam logic [7:0] MISC_BIT6_MASK = 8'h40;
  localparam logic [7:0] MISC_BIT7_MASK = 8'h80;
  localparam logic [7:0] CR7_PROT_KEEP = 8'h10;

  // Reset values and unlock key for the second lock register
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_TWO_VALUE = 8'ha5;
  localparam int NUM_EXT_REGS = 16;
  localparam logic [4:0] ATTR_PALETTE_LAST = 5'h0f;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } host_req_t;

  // Write forwarded to a downstream register, with per-bit write enables
  typedef struct packed {
    logic valid;
    logic [7:0] index;
    logic [7:0] data;
    logic [7:0] mask;
  } fwd_wr_t;

  typedef struct packed {
    logic video_out_clock_invert;
    logic snoop_method;
    logic snoop_no_mabort;
    logic snoop_no_retry;
    logic fifo_start_en;
    logic [7:0] fifo_start;
    logic force_8dot;
    logic [1:0] page_mode;
    logic [2:0] mem_size;
    logic outputs_hiz;
    logic internal_clocks;
    logic [2:0] panel_type;
    logic [1:0] refresh_count;
    logic pci_burst_off;
    logic interlace;
    logic [7:0] retrace_start;
    logic tv_en;
    logic [2:0] tv_sel;
    logic tv_mono;
    logic tv_pal;
    logic enh_access;
    logic cursor_en;
    logic cursor_space;
    logic ext_unlocked;
    logic sys_unlocked;
  } cfg_t;

endpackage

//--- src/crtc_ext_regs.sv
// Extended CRTC control register bank with unlock keys and write protection
// Functional notes
// - Second compat bit 1 lets CR7-protect bits 1 and 6 be written anyway.
// - Second compat bit 3 makes video output clock the inverted dot clock.
// - Second compat bit 4 drops host writes to palette DAC ports 3C6-3C9.
// - Second compat bit 5 holds blanking active whenever video is not active.
// - Second compat bit 6 drops writes to attribute palette registers 0 to F.
// - Third compat bits 0-2: snoop method, no master abort, no retry.
// - Programmed FIFO fetch start is used only while third compat bit 4 set.
// - Third compat bit 7 blocks writes to misc output bits 3-2.
// - Lock register bit 4 blocks vertical, bit 5 horizontal timing writes.
// - Lock bit 6 guards index 01h and misc bit 6; bit 7 index 12h, bit 7.
// - Config one bits 3-2 page mode, bits 7-5 memory size.
// - Config two bit 1 controls test mode, outputs floated.
// - Config two bit 3 picks internal clocks; bits 7-5 give panel type.
// - Indices 30h-3Ch other than keys 38h, 39h reachable only after correct key in first lock register.
// - System control and extension registers need correct key in second lock.
// - Misc bits 1-0 alternate refresh count, used only while bit 2 set.
// - Misc bit 7 set disables PCI burst read cycles.
// - Display FIFO fetch starts at fetch start register value when enabled.
// - With interlace bit 5 set, retrace begins at interlace start value.
// - TV bit 0 enable, bits 3-1 output, bit 4 mono, bit 5 NTSC/PAL.
// - Enhanced register access allowed only while system config bit 0 set.
// - Cursor bit 0 enables cursor, bit 4 reserves bitmap space at right.
// - After reset extended registers other than the key registers 38h, 39h are locked for reads and writes.
`timescale 1ns/1ps

module crtc_ext_regs
  import crtc_ext_pkg::*;
#(
  parameter logic [7:0] KEY_ONE_VALUE = 8'h4c,
  parameter logic [7:0] FIFO_START_DEFAULT = 8'h00,
  parameter logic [1:0] REFRESH_DEFAULT = 2'h0
)
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire host_req_t host_req_in,
  input wire logic active_video_in,
  input wire logic blank_in,
  output logic [7:0] host_rdata_out,
  output logic host_rhit_out,
  output fwd_wr_t crtc_wr_out,
  output fwd_wr_t misc_wr_out,
  output fwd_wr_t dac_wr_out,
  output fwd_wr_t attr_wr_out,
  output logic blank_out,
  output cfg_t cfg_out
);

  typedef struct packed {
    logic [NUM_EXT_REGS-1:0][7:0] ext;
    logic [7:0] index;
    logic vprot;
    logic color;
    logic attr_flip;
    logic [4:0] attr_index;
    logic [7:0] rdata;
    logic rhit;
    fwd_wr_t crtc_wr;
    fwd_wr_t misc_wr;
    fwd_wr_t dac_wr;
    fwd_wr_t attr_wr;
    logic blank;
    cfg_t cfg;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Map an index to its slot; bit 4 flags a hit
  function automatic logic [4:0] slot_of(input logic [7:0] idx);
    logic [4:0] r;
    r = 5'h00;
    if (idx >= IDX_COMPAT_CTRL_TWO && idx <= IDX_TV_OUTPUT_CONTROL)
    begin
      r = {1'b1, 4'(idx - IDX_COMPAT_CTRL_TWO)};
    end
    else if (idx >= IDX_SYSTEM_CONFIG && idx <= IDX_EXTENDED_MODE_CTRL)
    begin
      r = {1'b1, 4'(idx - IDX_SYSTEM_CONFIG + 8'h0b)};
    end
    else if (idx == IDX_CURSOR_MODE_CTRL)
    begin
      r = {1'b1, 4'hf};
    end
    return r;
  endfunction

  // Register value by index through the slot map
  function automatic logic [7:0] reg_of(input state_t st, input logic [7:0] idx);
    logic [4:0] sl;
    sl = slot_of(idx);
    return st.ext[sl[3:0]];
  endfunction

  function automatic logic is_horiz(input logic [7:0] idx);
    return idx <= IDX_HORIZ_LAST;
  endfunction

  // Vertical timing set: 06h, 07h, 09h, 10h-12h, 15h, 16h
  function automatic logic is_vert(input logic [7:0] idx);
    return idx == 8'h06 || idx == IDX_VERTICAL_OVERFLOW || idx == 8'h09 ||
           (idx >= 8'h10 && idx <= IDX_VERTICAL_DISPLAY_END) ||
           idx == 8'h15 || idx == 8'h16;
  endfunction

  logic [7:0] c2;
  logic [7:0] c3;
  logic [7:0] lk;
  logic key1_ok;
  logic key2_ok;
  logic [15:0] port_idx;
  logic [15:0] port_dat;
  logic [15:0] port_stat;
  logic [4:0] sl;
  logic in_key1_range;
  logic is_key_reg;
  logic access_ok;
  logic [7:0] mask;

  // Bank bytes that only feed the registered settings
  logic [7:0] mem_cfg;
  logic [7:0] chip_cfg;
  logic [7:0] misc_ctl;
  logic [7:0] mode_ctl;
  logic [7:0] tv_ctl;
  logic [7:0] sys_cfg;
  logic [7:0] cur_ctl;

  // Live copies of the control bytes the write gating needs
  always_comb
  begin
    c2 = reg_of(s_q, IDX_COMPAT_CTRL_TWO);
    c3 = reg_of(s_q, IDX_COMPAT_CTRL_THREE);
    lk = reg_of(s_q, IDX_CRT_WRITE_LOCK);
    key1_ok = reg_of(s_q, IDX_UNLOCK_KEY_ONE) == KEY_ONE_VALUE;
    key2_ok = reg_of(s_q, IDX_UNLOCK_KEY_TWO) == UNLOCK_KEY_TWO_VALUE;
    port_idx = s_q.color ? PORT_CRTC_IDX_COLOR : PORT_CRTC_IDX_MONO;
    port_dat = s_q.color ? PORT_CRTC_DAT_COLOR : PORT_CRTC_DAT_MONO;
    port_stat = s_q.color ? PORT_STATUS_COLOR : PORT_STATUS_MONO;
    sl = slot_of(s_q.index);
    in_key1_range = s_q.index >= IDX_KEY_ONE_RANGE_LO && s_q.index <= IDX_KEY_ONE_RANGE_HI;
    is_key_reg = s_q.index == IDX_UNLOCK_KEY_ONE || s_q.index == IDX_UNLOCK_KEY_TWO;
    // Key registers stay reachable, else nothing could ever unlock
    if (is_key_reg)
    begin
      access_ok = 1'b1;
    end
    else if (in_key1_range)
    begin
      access_ok = key1_ok;
    end
    else
    begin
      access_ok = key2_ok;
    end
  end

  // Whole bytes pulled out first; a function result cannot be bit-sliced
  always_comb
  begin
    mem_cfg = reg_of(s_q, IDX_MEMORY_CONFIG_ONE);
    chip_cfg = reg_of(s_q, IDX_CHIP_CONFIG_TWO);
    misc_ctl = reg_of(s_q, IDX_MISC_CONTROL_ONE);
    mode_ctl = reg_of(s_q, IDX_DISPLAY_MODE_CONTROL);
    tv_ctl = reg_of(s_q, IDX_TV_OUTPUT_CONTROL);
    sys_cfg = reg_of(s_q, IDX_SYSTEM_CONFIG);
    cur_ctl = reg_of(s_q, IDX_CURSOR_MODE_CTRL);
  end

  // Per-bit write enables for a standard CRTC register write
  always_comb
  begin
    mask = 8'hff;
    if (s_q.vprot && s_q.index <= IDX_VERTICAL_OVERFLOW)
    begin
      mask = 8'h00;
      if (s_q.index == IDX_VERTICAL_OVERFLOW)
      begin
        mask = CR7_PROT_KEEP;
        if (c2[B_C2_UNPROTECT_CR7])
        begin
          mask[B_CR7_UNPROT_A] = 1'b1;
          mask[B_CR7_UNPROT_B] = 1'b1;
        end
      end
    end
    if (lk[B_LK_VERT] && is_vert(s_q.index))
    begin
      mask = 8'h00;
    end
    if (lk[B_LK_HORIZ] && is_horiz(s_q.index))
    begin
      mask = 8'h00;
    end
    if (lk[B_LK_CR1_MISC6] && s_q.index == IDX_HORIZONTAL_DISPLAY_END)
    begin
      mask = 8'h00;
    end
    if (lk[B_LK_VERTICAL_DISPLAY_END_REG_MISC7] && s_q.index == IDX_VERTICAL_DISPLAY_END)
    begin
      mask = 8'h00;
    end
  end

  // Next state: host decode, forwarding and derived settings
  always_comb
  begin
    s_d = s_q;
    s_d.rhit = 1'b0;
    s_d.rdata = 8'h00;
    s_d.crtc_wr.valid = 1'b0;
    s_d.misc_wr.valid = 1'b0;
    s_d.dac_wr.valid = 1'b0;
    s_d.attr_wr.valid = 1'b0;

    if (host_req_in.wr)
    begin
      if (host_req_in.addr == port_idx)
      begin
        s_d.index = host_req_in.data;
      end
      else if (host_req_in.addr == port_dat)
      begin
        if (sl[4])
        begin
          // Locked writes vanish without a trace
          if (access_ok)
          begin
            s_d.ext[sl[3:0]] = host_req_in.data;
          end
        end
        else if (s_q.index < IDX_KEY_ONE_RANGE_LO)
        begin
          s_d.crtc_wr.valid = 1'b1;
          s_d.crtc_wr.index = s_q.index;
          s_d.crtc_wr.data = host_req_in.data;
          s_d.crtc_wr.mask = mask;
          // Shadow of the protect bit; updated only while bit 7 of the write mask is set, so lock bit 4 blocks it
          if (s_q.index == IDX_VERTICAL_RETRACE_END && mask[B_VERTICAL_RETRACE_END_REG_PROTECT])
          begin
            s_d.vprot = host_req_in.data[B_VERTICAL_RETRACE_END_REG_PROTECT];
          end
        end
      end
      else if (host_req_in.addr == PORT_MISC_OUT_WR)
      begin
        s_d.misc_wr.valid = 1'b1;
        s_d.misc_wr.index = 8'h00;
        s_d.misc_wr.data = host_req_in.data;
        s_d.misc_wr.mask = 8'hff;
        if (c3[B_C3_DOT_CLOCK_SEL_LOCK])
        begin
          s_d.misc_wr.mask = s_d.misc_wr.mask & ~MISC_DOT_CLOCK_MASK;
        end
        if (lk[B_LK_CR1_MISC6])
        begin
          s_d.misc_wr.mask = s_d.misc_wr.mask & ~MISC_BIT6_MASK;
        end
        if (lk[B_LK_VERTICAL_DISPLAY_END_REG_MISC7])
        begin
          s_d.misc_wr.mask = s_d.misc_wr.mask & ~MISC_BIT7_MASK;
        end
        s_d.color = host_req_in.data[0];
      end
      else if (host_req_in.addr >= PORT_DAC_FIRST && host_req_in.addr <= PORT_DAC_LAST)
      begin
        s_d.dac_wr.valid = !c2[B_C2_DAC_WR_OFF];
        s_d.dac_wr.index = host_req_in.addr[7:0];
        s_d.dac_wr.data = host_req_in.data;
        s_d.dac_wr.mask = 8'hff;
      end
      else if (host_req_in.addr == PORT_ATTR)
      begin
        // Attribute port alternates index and data phases
        s_d.attr_flip = !s_q.attr_flip;
        if (!s_q.attr_flip)
        begin
          s_d.attr_index = host_req_in.data[4:0];
        end
        else
        begin
          s_d.attr_wr.valid = !(c2[B_C2_ATTR_WR_OFF] &&
                                s_q.attr_index <= ATTR_PALETTE_LAST);
          s_d.attr_wr.index = {3'h0, s_q.attr_index};
          s_d.attr_wr.data = host_req_in.data;
          s_d.attr_wr.mask = 8'hff;
        end
      end
    end
    else if (host_req_in.rd)
    begin
      if (host_req_in.addr == port_idx)
      begin
        s_d.rhit = 1'b1;
        s_d.rdata = s_q.index;
      end
      else if (host_req_in.addr == port_dat && sl[4])
      begin
        s_d.rhit = 1'b1;
        s_d.rdata = access_ok ? s_q.ext[sl[3:0]] : 8'h00;
      end
      else if (host_req_in.addr == port_stat)
      begin
        // Status read rewinds the attribute port to its index phase
        s_d.attr_flip = 1'b0;
      end
    end

    // Blanking extended over every non-active period
    s_d.blank = blank_in || (c2[B_C2_BLANK_FORCE] && !active_video_in);

    // Settings registered from the bank
    s_d.cfg.video_out_clock_invert = c2[B_C2_VIDEO_OUT_CLOCK_INVERT];
    s_d.cfg.snoop_method = c3[B_C3_SNOOP_METHOD];
    s_d.cfg.snoop_no_mabort = c3[B_C3_NO_MABORT];
    s_d.cfg.snoop_no_retry = c3[B_C3_NO_RETRY];
    s_d.cfg.fifo_start_en = c3[B_C3_FIFO_START_EN];
    // Fetch start falls back to the default while its enable is off
    s_d.cfg.fifo_start = c3[B_C3_FIFO_START_EN] ?
                         reg_of(s_q, IDX_FIFO_FETCH_START) : FIFO_START_DEFAULT;
    s_d.cfg.force_8dot = c3[B_C3_FORCE_8DOT];
    s_d.cfg.page_mode = mem_cfg[3:2];
    s_d.cfg.mem_size = mem_cfg[7:5];
    s_d.cfg.outputs_hiz = chip_cfg[B_CF2_TEST_MODE];
    s_d.cfg.internal_clocks = chip_cfg[B_CF2_INTERNAL_CLK];
    s_d.cfg.panel_type = chip_cfg[7:5];
    // Alternate refresh count only while its enable bit is set
    s_d.cfg.refresh_count = misc_ctl[B_MC_REFRESH_ALT_EN] ?
                            misc_ctl[1:0] : REFRESH_DEFAULT;
    s_d.cfg.pci_burst_off = misc_ctl[B_MC_PCI_BURST_OFF];
    s_d.cfg.interlace = mode_ctl[B_DM_INTERLACE];
    s_d.cfg.retrace_start = reg_of(s_q, IDX_INTERLACE_RETRACE_START);
    s_d.cfg.tv_en = tv_ctl[B_TV_EN];
    s_d.cfg.tv_sel = tv_ctl[3:1];
    s_d.cfg.tv_mono = tv_ctl[B_TV_MONO];
    s_d.cfg.tv_pal = tv_ctl[B_TV_PAL];
    s_d.cfg.enh_access = sys_cfg[B_SC_ENH_ACCESS];
    s_d.cfg.cursor_en = cur_ctl[B_CUR_EN];
    s_d.cfg.cursor_space = cur_ctl[B_CUR_SPACE];
    s_d.cfg.ext_unlocked = key1_ok;
    s_d.cfg.sys_unlocked = key2_ok;
  end

  // Single state register; reset clears keys, so the bank starts locked
  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      s_q <= '0;
      for (int i = 0; i < NUM_EXT_REGS; i++)
      begin
        s_q.ext[i] <= REG_RESET;
      end
      s_q.cfg.fifo_start <= FIFO_START_DEFAULT;
      s_q.cfg.refresh_count <= REFRESH_DEFAULT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign host_rdata_out = s_q.rdata;
  assign host_rhit_out = s_q.rhit;
  assign crtc_wr_out = s_q.crtc_wr;
  assign misc_wr_out = s_q.misc_wr;
  assign dac_wr_out = s_q.dac_wr;
  assign attr_wr_out = s_q.attr_wr;
  assign blank_out = s_q.blank;
  assign cfg_out = s_q.cfg;

endmodule

//--- verification/crtc_ext_props.sv
// Concurrent checks on the ports of the extended CRTC register bank
`timescale 1ns/1ps

module crtc_ext_props
  import crtc_ext_pkg::*;
#(
  parameter logic [7:0] KEY_ONE_VALUE = 8'h4c,
  parameter logic [7:0] FIFO_START_DEFAULT = 8'h00
)
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire host_req_t host_req_in,
  input wire logic active_video_in,
  input wire logic blank_in,
  input wire logic [7:0] host_rdata_out,
  input wire logic host_rhit_out,
  input wire fwd_wr_t crtc_wr_out,
  input wire fwd_wr_t misc_wr_out,
  input wire fwd_wr_t dac_wr_out,
  input wire fwd_wr_t attr_wr_out,
  input wire logic blank_out,
  input wire cfg_t cfg_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  // Host write aimed at the palette ports
  sequence dac_write_s;
    host_req_in.wr && host_req_in.addr inside {[PORT_DAC_FIRST:PORT_DAC_LAST]};
  endsequence
  // Keys show up in the config two edges after their data cycle
  sequence key_one_s;
    $rose(cfg_out.ext_unlocked);
  endsequence
  sequence key_two_s;
    $rose(cfg_out.sys_unlocked);
  endsequence

  reset_lock_a:
    assert property ($rose(nrst_in) |-> !cfg_out.ext_unlocked && !cfg_out.sys_unlocked)
    else $error("bank unlocked right after reset");
  key_one_a:
    assert property (key_one_s |-> $past(host_req_in.wr, 2) &&
      $past(host_req_in.data, 2) == KEY_ONE_VALUE)
    else $error("first lock opened without its key");
  key_two_a:
    assert property (key_two_s |-> $past(host_req_in.wr, 2) &&
      $past(host_req_in.data, 2) == UNLOCK_KEY_TWO_VALUE)
    else $error("second lock opened without its key");
  fifo_default_a:
    assert property (!cfg_out.fifo_start_en |-> cfg_out.fifo_start == FIFO_START_DEFAULT)
    else $error("fetch start used while disabled");
  dac_fwd_a:
    assert property (dac_write_s ##1 dac_wr_out.valid |->
      dac_wr_out.data == $past(host_req_in.data) &&
      dac_wr_out.index == $past(host_req_in.addr[7:0]))
    else $error("palette write forwarded wrongly");
  dac_only_a:
    assert property (!(host_req_in.wr && host_req_in.addr inside
      {[PORT_DAC_FIRST:PORT_DAC_LAST]}) |=> !dac_wr_out.valid)
    else $error("palette write from nowhere");
  blank_pass_a:
    assert property (blank_in |=> blank_out)
    else $error("timing blank not passed on");
  blank_video_a:
    assert property (active_video_in && !blank_in |=> !blank_out)
    else $error("blank during active video");
  misc_mask_a:
    assert property (misc_wr_out.valid |-> (misc_wr_out.mask & 8'h33) == 8'h33)
    else $error("unlocked misc bit masked");
  crtc_low_a:
    assert property (crtc_wr_out.valid |-> crtc_wr_out.index < IDX_KEY_ONE_RANGE_LO)
    else $error("bank index forwarded to crtc");
  read_hit_a:
    assert property (host_rhit_out |-> $past(host_req_in.rd) && !$past(host_req_in.wr))
    else $error("read answer without read");
endmodule

bind crtc_ext_regs crtc_ext_props #(
  .KEY_ONE_VALUE(KEY_ONE_VALUE),
  .FIFO_START_DEFAULT(FIFO_START_DEFAULT)
) props_u (
  .core_clk_in, .nrst_in, .host_req_in, .active_video_in, .blank_in,
  .host_rdata_out, .host_rhit_out, .crtc_wr_out, .misc_wr_out,
  .dac_wr_out, .attr_wr_out, .blank_out, .cfg_out
);

//--- verification/host_model.sv
// Host side model issuing single byte I/O cycles to the bank
`timescale 1ns/1ps

module host_model
  import crtc_ext_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [7:0] host_rdata_in,
  input wire logic host_rhit_in,
  output host_req_t host_req_out
);
  // Idle bus at time zero
  initial
  begin
    host_req_out = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, data: 8'h00};
  end

  // One-cycle strobe; released fields flip so stale values never match
  task automatic io_cycle(input logic wr, input logic [15:0] a, input logic [7:0] dt);
    @(posedge core_clk_in);
    host_req_out <= '{wr: wr, rd: ~wr, addr: a, data: dt};
    @(posedge core_clk_in);
    host_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~dt};
    #1;
  endtask

  task automatic io_wr(input logic [15:0] a, input logic [7:0] dt);
    io_cycle(1'b1, a, dt);
  endtask

  // Answer is taken one cycle after the strobe edge
  task automatic io_rd(input logic [15:0] a, output logic [7:0] dt, output logic hit);
    io_cycle(1'b0, a, 8'h00);
    dt = host_rdata_in;
    hit = host_rhit_in;
  endtask

  // Second key opens the system group until overwritten
  task automatic unlock_two;
    io_wr(PORT_CRTC_IDX_MONO, IDX_UNLOCK_KEY_TWO);
    io_wr(PORT_CRTC_DAT_MONO, UNLOCK_KEY_TWO_VALUE);
  endtask
endmodule

//--- verification/testbench.sv
// Register level testbench for the extended CRTC register bank
`timescale 1ns/1ps

module testbench;
  import crtc_ext_pkg::*;
  localparam logic [7:0] KEY1 = 8'h5e;
  localparam logic [7:0] FDEF = 8'h17;
  localparam logic [1:0] RDEF = 2'h2;
  // Index and value pairs for the bank fill
  localparam logic [15:0] BANK [11] = '{16'h3308, 16'h3417, 16'h36ac, 16'h37aa,
    16'h3a85, 16'h3b5c, 16'h3c3e, 16'h3d2b, 16'h4001, 16'h4220, 16'h4511};
  // Lock value, crtc index, expected write mask
  localparam logic [23:0] LOCKS [9] = '{24'hf00100, 24'h400100, 24'h801200,
    24'h200400, 24'h100600, 24'h1004ff, 24'h2006ff, 24'hf013ff, 24'h0001ff};
  logic core_clk_in;
  logic nrst_in;
  host_req_t host_req_in;
  logic active_video_in;
  logic blank_in;
  logic [7:0] host_rdata_out;
  logic host_rhit_out;
  fwd_wr_t crtc_wr_out, misc_wr_out, dac_wr_out, attr_wr_out;
  logic blank_out;
  cfg_t cfg_out;
  cfg_t exp_cfg;
  logic [7:0] d;
  logic h;
  int errors = 0;
  int checked = 0;

  crtc_ext_regs #(.KEY_ONE_VALUE(KEY1), .FIFO_START_DEFAULT(FDEF), .REFRESH_DEFAULT(RDEF)) dut (
    .core_clk_in, .nrst_in, .host_req_in, .active_video_in, .blank_in,
    .host_rdata_out, .host_rhit_out, .crtc_wr_out, .misc_wr_out,
    .dac_wr_out, .attr_wr_out, .blank_out, .cfg_out
  );

  host_model host (
    .core_clk_in, .host_rdata_in(host_rdata_out), .host_rhit_in(host_rhit_out),
    .host_req_out(host_req_in)
  );

  // 200 MHz clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  task automatic close_out;
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Indexed access through the mono port pair
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    host.io_wr(PORT_CRTC_IDX_MONO, idx);
    host.io_wr(PORT_CRTC_DAT_MONO, val);
  endtask

  task automatic reg_rd(input logic [7:0] idx);
    host.io_wr(PORT_CRTC_IDX_MONO, idx);
    host.io_rd(PORT_CRTC_DAT_MONO, d, h);
  endtask

  // Config and blank lag the bank by a cycle; two edges is safe
  task automatic settle;
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask

  task automatic blk(input logic av, input logic bl, input logic e);
    @(posedge core_clk_in);
    active_video_in <= av;
    blank_in <= bl;
    settle();
    chk(64'(blank_out), 64'(e));
  endtask

  task automatic attr_try(input logic [7:0] c2, input logic e);
    reg_wr(IDX_COMPAT_CTRL_TWO, c2);
    host.io_rd(PORT_STATUS_MONO, d, h);
    host.io_wr(PORT_ATTR, 8'h05);
    host.io_wr(PORT_ATTR, 8'h2a);
    chk(64'(attr_wr_out.valid), 64'(e));
    chk(64'({attr_wr_out.index, attr_wr_out.data}), 64'(16'h052a));
  endtask

  task automatic dac_try(input logic [7:0] c2, input logic e);
    reg_wr(IDX_COMPAT_CTRL_TWO, c2);
    host.io_wr(16'h03c8, 8'h3f);
    chk(64'(dac_wr_out.valid), 64'(e));
  endtask

  task automatic misc_try(input logic [7:0] c3, input logic [7:0] lk, input logic [7:0] m);
    reg_wr(IDX_COMPAT_CTRL_THREE, c3);
    reg_wr(IDX_CRT_WRITE_LOCK, lk);
    host.io_wr(PORT_MISC_OUT_WR, 8'hfe);
    chk(64'(misc_wr_out.mask), 64'(m));
  endtask

  // Hang guard, far beyond the few hundred cycles of the sequence
  initial
  begin
    #50000;
    errors++;
    close_out();
  end

  // Main sequence
  initial
  begin
    nrst_in = 1'b0;
    active_video_in = 1'b1;
    blank_in = 1'b0;
    repeat (4) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    #1;
    exp_cfg = '0;
    exp_cfg.fifo_start = FDEF;
    exp_cfg.refresh_count = RDEF;
    chk(64'(cfg_out), 64'(exp_cfg));
    reg_wr(IDX_COMPAT_CTRL_TWO, 8'hff);
    reg_rd(IDX_COMPAT_CTRL_TWO);
    chk(64'({h, d}), 64'(9'h100));
    reg_wr(IDX_UNLOCK_KEY_ONE, 8'ha1);
    reg_wr(IDX_FIFO_FETCH_START, 8'h33);
    reg_wr(IDX_UNLOCK_KEY_ONE, KEY1);
    reg_rd(IDX_FIFO_FETCH_START);
    chk(64'(d), 64'(8'h00));
    reg_wr(IDX_TV_OUTPUT_CONTROL, 8'h21);
    reg_rd(IDX_TV_OUTPUT_CONTROL);
    chk(64'(d), 64'(8'h00));
    host.unlock_two();
    foreach (BANK[i])
      reg_wr(BANK[i][15:8], BANK[i][7:0]);
    foreach (BANK[i])
    begin
      reg_rd(BANK[i][15:8]);
      chk(64'(d), 64'(BANK[i][7:0]));
    end
    settle();
    exp_cfg = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h5c, 1'b0, 2'h3, 3'h5, 1'b1, 1'b1, 3'h5,
      2'h1, 1'b1, 1'b1, 8'h3e, 1'b1, 3'h5, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    chk(64'(cfg_out), 64'(exp_cfg));
    reg_wr(IDX_COMPAT_CTRL_THREE, 8'h07);
    reg_wr(IDX_MISC_CONTROL_ONE, 8'h81);
    settle();
    exp_cfg.fifo_start_en = 1'b0;
    exp_cfg.fifo_start = FDEF;
    exp_cfg.refresh_count = RDEF;
    chk(64'(cfg_out), 64'(exp_cfg));
    reg_rd(8'h44);
    chk(64'(h), 64'(1'b0));
    dac_try(8'h08, 1'b1);
    dac_try(8'h18, 1'b0);
    attr_try(8'h08, 1'b1);
    attr_try(8'h48, 1'b0);
    reg_wr(IDX_COMPAT_CTRL_TWO, 8'h20);
    blk(1'b0, 1'b0, 1'b1);
    blk(1'b1, 1'b0, 1'b0);
    blk(1'b1, 1'b1, 1'b1);
    reg_wr(IDX_COMPAT_CTRL_TWO, 8'h00);
    blk(1'b0, 1'b0, 1'b0);
    blk(1'b1, 1'b0, 1'b0);
    misc_try(8'h80, 8'h40, 8'hb3);
    misc_try(8'h00, 8'h80, 8'h7f);
    foreach (LOCKS[i])
    begin
      reg_wr(IDX_CRT_WRITE_LOCK, LOCKS[i][23:16]);
      reg_wr(LOCKS[i][15:8], 8'h5a);
      chk(64'(crtc_wr_out.mask), 64'(LOCKS[i][7:0]));
    end
    reg_wr(IDX_VERTICAL_RETRACE_END, 8'h80);
    reg_wr(IDX_VERTICAL_OVERFLOW, 8'hff);
    chk(64'(crtc_wr_out.mask), 64'(8'h10));
    reg_wr(IDX_COMPAT_CTRL_TWO, 8'h02);
    reg_wr(IDX_VERTICAL_OVERFLOW, 8'hff);
    chk(64'(crtc_wr_out.mask), 64'(8'h52));
    chk(64'({crtc_wr_out.valid, crtc_wr_out.index, crtc_wr_out.data}),
      64'({1'b1, IDX_VERTICAL_OVERFLOW, 8'hff}));
    reg_wr(IDX_UNLOCK_KEY_TWO, 8'h00);
    settle();
    chk(64'(cfg_out.sys_unlocked), 64'(1'b0));
    reg_rd(IDX_TV_OUTPUT_CONTROL);
    chk(64'(d), 64'(8'h00));
    reg_wr(IDX_UNLOCK_KEY_ONE, 8'h00);
    reg_rd(IDX_COMPAT_CTRL_TWO);
    chk(64'({h, d}), 64'(9'h100));
    // Switch to colour addressing and reach the bank through the other port pair
    host.io_wr(PORT_MISC_OUT_WR, 8'h01);
    chk(64'(misc_wr_out), 64'({1'b1, 8'h00, 8'h01, 8'hff}));
    host.io_wr(PORT_CRTC_IDX_COLOR, IDX_COMPAT_CTRL_TWO);
    host.io_rd(PORT_CRTC_IDX_COLOR, d, h);
    chk(64'({h, d}), 64'({1'b1, IDX_COMPAT_CTRL_TWO}));
    host.io_rd(PORT_CRTC_DAT_COLOR, d, h);
    chk(64'({h, d}), 64'(9'h100));
    close_out();
  end
endmodule
